// ===== pkg/asrc_regs.svh
// timing constants for the async sram host controller
`ifndef ASRC_REGS_SVH
`define ASRC_REGS_SVH
`define ASRC_CLK_PERIOD_NS 20
`define ASRC_ADDR_W 14
`define ASRC_DATA_W 4
`define ASRC_T_RC_NS 25
`define ASRC_T_AA_NS 25
`define ASRC_T_WP_NS 20
`define ASRC_T_DW_NS 13
`define ASRC_T_WZ_NS 7
`define ASRC_T_HZ_NS 10
`define ASRC_T_WR_NS 0
// least times round up, none below one cycle
`define ASRC_CYC_MIN(t) (((t) + `ASRC_CLK_PERIOD_NS - 1) / \
  `ASRC_CLK_PERIOD_NS < 1 ? 1 : ((t) + `ASRC_CLK_PERIOD_NS - 1) / \
  `ASRC_CLK_PERIOD_NS)
`define ASRC_RD_CYC `ASRC_CYC_MIN(`ASRC_T_AA_NS)
`define ASRC_WP_CYC `ASRC_CYC_MIN(`ASRC_T_WP_NS)
`define ASRC_WZ_CYC `ASRC_CYC_MIN(`ASRC_T_WZ_NS)
`define ASRC_HZ_CYC `ASRC_CYC_MIN(`ASRC_T_HZ_NS)
`define ASRC_CNT_W 4
`endif

// ===== pkg/asrc_pkg.sv
// types for the async sram host controller
package asrc_pkg;
  typedef enum logic [5:0] {
    ST_IDLE  = 6'b00_0001,
    ST_ASET  = 6'b00_0010,
    ST_RD    = 6'b00_0100,
    ST_WZ    = 6'b00_1000,
    ST_WP    = 6'b01_0000,
    ST_REC   = 6'b10_0000
  } asrc_state_type;
endpackage

// ===== design/asrc_sync.sv
// two-stage synchroniser for the returned data pins
`timescale 1ns/1ns
module asrc_sync
  import asrc_pkg::*;
#(
  parameter int WIDTH = 4
) (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst,
  // asynchronous bits in, synchronised bits out
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_sync
);
  logic [WIDTH-1:0] meta_ff;
  logic [WIDTH-1:0] sync_ff;

  // per-bit double flop; first stage read only by the second
  genvar gi;
  generate
    for (gi = 0; gi < WIDTH; gi++) begin : g_bit
      always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
          meta_ff[gi] <= 1'b0;
          sync_ff[gi] <= 1'b0;
        end else begin
          meta_ff[gi] <= i_async[gi];
          sync_ff[gi] <= meta_ff[gi];
        end
      end
    end
  endgenerate

  assign o_sync = sync_ff;
endmodule

// ===== design/asrc_host.sv
// host controller driving a 16k by 4 asynchronous static memory
// Operation
// - read: chip select low, write strobe high, device drives stored word
// - host keeps strobe or chip select high whenever address changes
// - write recovery measured from first of chip select or strobe rising
// - host drives write data only after device output-disable delay
// - host sets write data 13 ns before write end, zero hold
// - host holds chip select low 20 ns before write end
// - host holds address 20 ns before write end, zero setup
// - address valid before or with chip select falling on reads
// - read timing counted from last valid to next changing address
// - host deasserts chip select before data retention begins; the code only refuses new requests, an accepted access still takes select low
`timescale 1ns/1ns
`include "asrc_regs.svh"
module asrc_host
  import asrc_pkg::*;
(
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst,
  // user request side
  input wire logic i_req,
  input wire logic i_req_write,
  input wire logic [`ASRC_ADDR_W-1:0] i_req_addr,
  input wire logic [`ASRC_DATA_W-1:0] i_req_wdata,
  input wire logic i_retain,
  output logic o_req_ready,
  output logic o_rd_valid,
  output logic [`ASRC_DATA_W-1:0] o_rd_data,
  // memory pins
  output logic [`ASRC_ADDR_W-1:0] o_word_address,
  output logic o_chip_sel_n,
  output logic o_write_n,
  input wire logic [`ASRC_DATA_W-1:0] i_data_in,
  output logic [`ASRC_DATA_W-1:0] o_data_out,
  output logic o_data_oe
);
  typedef struct packed {
    asrc_state_type st;
    logic [`ASRC_CNT_W-1:0] cnt;
    logic wr;
    logic [`ASRC_ADDR_W-1:0] addr;
    logic [`ASRC_DATA_W-1:0] wdata;
    logic cs_n;
    logic we_n;
    logic oe;
    logic ready;
    logic rd_valid;
    logic [`ASRC_DATA_W-1:0] rd_data;
  } asrc_host_state_type;

  localparam logic [`ASRC_CNT_W-1:0] RD_CYC = `ASRC_CNT_W'(`ASRC_RD_CYC);
  localparam logic [`ASRC_CNT_W-1:0] WP_CYC = `ASRC_CNT_W'(`ASRC_WP_CYC);
  localparam logic [`ASRC_CNT_W-1:0] WZ_CYC = `ASRC_CNT_W'(`ASRC_WZ_CYC);
  localparam logic [`ASRC_CNT_W-1:0] HZ_CYC = `ASRC_CNT_W'(`ASRC_HZ_CYC);
  // synchroniser adds two cycles to the pin data path
  localparam logic [`ASRC_CNT_W-1:0] SY_CYC = 4'h2;

  asrc_host_state_type cur_ff;
  asrc_host_state_type nxt_cur;
  logic [`ASRC_DATA_W-1:0] data_sync;

  // data pins come from outside the clock domain
  asrc_sync #(.WIDTH(`ASRC_DATA_W)) u_sync (
    .i_core_clk(i_core_clk),
    .i_rst(i_rst),
    .i_async(i_data_in),
    .o_sync(data_sync)
  );

  // next-state logic of the access sequencer
  always_comb begin
    nxt_cur = cur_ff;
    nxt_cur.rd_valid = 1'b0;
    unique case (cur_ff.st)
      ST_IDLE: begin
        nxt_cur.cs_n = 1'b1;
        nxt_cur.we_n = 1'b1;
        nxt_cur.oe = 1'b0;
        nxt_cur.ready = ~i_retain;
        if (i_req && cur_ff.ready && !i_retain) begin
          // address changes only with both strobes high
          nxt_cur.addr = i_req_addr;
          nxt_cur.wr = i_req_write;
          nxt_cur.wdata = i_req_wdata;
          nxt_cur.ready = 1'b0;
          nxt_cur.st = ST_ASET;
        end
      end
      ST_ASET: begin
        // select after address settled a cycle
        nxt_cur.cs_n = 1'b0;
        nxt_cur.cnt = cur_ff.wr ? WZ_CYC : RD_CYC + SY_CYC;
        nxt_cur.we_n = ~cur_ff.wr; // strobe falls with select
        nxt_cur.st = cur_ff.wr ? ST_WZ : ST_RD;
      end
      ST_RD: begin
        // wait access time plus sync delay, then capture
        if (cur_ff.cnt == 4'h1) begin
          nxt_cur.rd_data = data_sync;
          nxt_cur.rd_valid = 1'b1;
          nxt_cur.cs_n = 1'b1;
          nxt_cur.cnt = HZ_CYC;
          nxt_cur.st = ST_REC;
        end else begin
          nxt_cur.cnt = cur_ff.cnt - 4'h1;
        end
      end
      ST_WZ: begin
        // let the device float before we drive
        if (cur_ff.cnt == 4'h1) begin
          nxt_cur.oe = 1'b1;
          nxt_cur.cnt = WP_CYC;
          nxt_cur.st = ST_WP;
        end else begin
          nxt_cur.cnt = cur_ff.cnt - 4'h1;
        end
      end
      ST_WP: begin
        // data, select and address held through the pulse
        if (cur_ff.cnt == 4'h1) begin
          nxt_cur.we_n = 1'b1;
          nxt_cur.cs_n = 1'b1;
          nxt_cur.cnt = HZ_CYC;
          nxt_cur.st = ST_REC;
        end else begin
          nxt_cur.cnt = cur_ff.cnt - 4'h1;
        end
      end
      ST_REC: begin
        // data held a cycle past write end, then released
        nxt_cur.oe = 1'b0;
        if (cur_ff.cnt == 4'h1) begin
          nxt_cur.ready = ~i_retain;
          nxt_cur.st = ST_IDLE;
        end else begin
          nxt_cur.cnt = cur_ff.cnt - 4'h1;
        end
      end
      default: begin
        nxt_cur.st = ST_IDLE;
        nxt_cur.cs_n = 1'b1;
        nxt_cur.we_n = 1'b1;
        nxt_cur.oe = 1'b0;
      end
    endcase
  end

  // state register
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      cur_ff <= '{st: ST_IDLE, cnt: '0, wr: 1'b0, addr: '0, wdata: '0,
                 cs_n: 1'b1, we_n: 1'b1, oe: 1'b0, ready: 1'b0,
                 rd_valid: 1'b0, rd_data: '0};
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  // outputs straight from the state flops
  assign o_word_address = cur_ff.addr;
  assign o_chip_sel_n = cur_ff.cs_n;
  assign o_write_n = cur_ff.we_n;
  assign o_data_out = cur_ff.wdata;
  assign o_data_oe = cur_ff.oe;
  assign o_req_ready = cur_ff.ready;
  assign o_rd_valid = cur_ff.rd_valid;
  assign o_rd_data = cur_ff.rd_data;

  // address moves only with select high in that cycle and the one before
  a_addr_stable: assert property (
    @(posedge i_core_clk) disable iff (i_rst)
    $changed(o_word_address) |-> $past(o_chip_sel_n) && o_chip_sel_n)
    else $error("address moved while selected");

  // write pulse lasts the full width with select low
  a_write_pulse: assert property (
    @(posedge i_core_clk) disable iff (i_rst)
    $fell(o_write_n) |-> (!o_write_n && !o_chip_sel_n) [*2])
    else $error("write pulse too short");

  // data driven through the last pulse cycle and held past its end
  a_data_setup: assert property (
    @(posedge i_core_clk) disable iff (i_rst)
    $rose(o_write_n) |-> $past(o_data_oe) && o_data_oe)
    else $error("write data not held across write end");

  // never drive data while a read is possible
  a_no_contention: assert property (
    @(posedge i_core_clk) disable iff (i_rst)
    o_data_oe |-> o_write_n == 1'b0 || $past(o_write_n) == 1'b0)
    else $error("data driven outside a write");

  // strobe never low without select low
  a_strobe_sel: assert property (
    @(posedge i_core_clk) disable iff (i_rst)
    !o_write_n |-> !o_chip_sel_n)
    else $error("strobe low without select");

  // read result arrives a fixed time after select falls
  a_read_time: assert property (
    @(posedge i_core_clk) disable iff (i_rst)
    ($fell(o_chip_sel_n) && o_write_n) |-> ##4 o_rd_valid)
    else $error("read result not on time");

  // select released together with read capture
  a_read_end: assert property (
    @(posedge i_core_clk) disable iff (i_rst)
    o_rd_valid |-> $rose(o_chip_sel_n))
    else $error("select not released at read end");

  // retain refuses requests, so select stays high two cycles on
  a_retain_idle: assert property (
    @(posedge i_core_clk) disable iff (i_rst)
    (i_retain && o_chip_sel_n && cur_ff.st == ST_IDLE)
      |=> !o_req_ready ##1 o_chip_sel_n)
    else $error("request accepted while retaining");

  // address valid one cycle before select falls
  a_addr_first: assert property (
    @(posedge i_core_clk) disable iff (i_rst)
    $fell(o_chip_sel_n) |-> $stable(o_word_address))
    else $error("address moved as select fell");
endmodule

// ===== dv/asrc_mem_model.sv
// behavioural model of the 16k by 4 asynchronous static memory
`timescale 1ns/1ns
module asrc_mem_model #(
  parameter int T_ACC = 25,
  parameter int T_OFF = 7
) (
  // memory pins as seen by the device
  input wire logic [13:0] i_word_address,
  input wire logic i_chip_sel_n,
  input wire logic i_write_n,
  input wire logic [3:0] i_dq,
  output logic [3:0] o_dq,
  output logic o_dq_oe
);
  logic [3:0] mem [0:16383];
  logic rd;

  // read mode only with select low and strobe high
  assign rd = !i_chip_sel_n && i_write_n;
  // store while select and strobe are both low
  always @* begin
    if (!i_chip_sel_n && !i_write_n) mem[i_word_address] = i_dq;
  end
  // old word held briefly, then unknown until the access time
  always @(i_word_address or rd) begin
    o_dq <= #5 4'hx;
    o_dq <= #(T_ACC) mem[i_word_address];
  end
  // late turn-on, release within the disable delay
  always @(rd) begin
    if (rd) o_dq_oe <= #5 1'b1;
    else o_dq_oe <= #(T_OFF) 1'b0;
  end
  initial o_dq_oe = 1'b0;
endmodule

// ===== dv/tb_top.sv
// self-checking bench for the async sram host controller
`timescale 1ns/1ns
module tb_top;
  logic i_core_clk = 1'b0;
  logic i_rst = 1'b1;
  logic i_req = 1'b0;
  logic i_req_write = 1'b0;
  logic i_retain = 1'b0;
  logic [13:0] i_req_addr = 14'h0000;
  logic [13:0] addr;
  logic [3:0] i_req_wdata = 4'h0;
  logic [3:0] dq, dev_dq, o_rd_data, o_data_out;
  logic [3:0] last = 4'h0;
  logic o_req_ready, o_rd_valid, cs_n, we_n, oe, dev_oe;
  int n_fail = 0;
  int comparisons = 0;

  always #10 i_core_clk = ~i_core_clk;
  // released data lines show the inverse of their last level
  assign dq = oe ? o_data_out : dev_oe ? dev_dq : ~last;
  always @(dq) if (oe || dev_oe) last = dq;

  asrc_host asrc_host_i (.i_core_clk(i_core_clk), .i_rst(i_rst),
    .i_req(i_req), .i_req_write(i_req_write), .i_req_addr(i_req_addr),
    .i_req_wdata(i_req_wdata), .i_retain(i_retain),
    .o_req_ready(o_req_ready), .o_rd_valid(o_rd_valid),
    .o_rd_data(o_rd_data), .o_word_address(addr), .o_chip_sel_n(cs_n),
    .o_write_n(we_n), .i_data_in(dq), .o_data_out(o_data_out),
    .o_data_oe(oe));
  asrc_mem_model asrc_mem_model_i (.i_word_address(addr),
    .i_chip_sel_n(cs_n), .i_write_n(we_n), .i_dq(dq), .o_dq(dev_dq),
    .o_dq_oe(dev_oe));

  task automatic chk(string what, logic [13:0] exp, logic [13:0] got);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %s exp %h got %h", what, exp, got);
    end
  endtask
  // bounded wait for the controller to accept again
  task automatic wait_ready();
    int n;
    n = 0;
    do begin
      @(posedge i_core_clk);
      #1;
      n++;
    end while (o_req_ready !== 1'b1 && n < 20);
    chk("ready back", 14'h1, {13'h0, o_req_ready});
  endtask
  task automatic req(logic wr, logic [13:0] a, logic [3:0] d);
    wait_ready();
    @(posedge i_core_clk);
    i_req <= 1'b1;
    i_req_write <= wr;
    i_req_addr <= a;
    i_req_wdata <= d;
    @(posedge i_core_clk);
    i_req <= 1'b0;
  endtask
  task automatic wr(logic [13:0] a, logic [3:0] d);
    logic [3:0] got;
    req(1'b1, a, d);
    wait_ready();
    got = asrc_mem_model_i.mem[a];
    chk("stored word", {10'h000, d}, {10'h000, got});
  endtask
  task automatic rd(logic [13:0] a, logic [3:0] exp);
    int n;
    req(1'b0, a, 4'h0);
    n = 0;
    do begin
      @(posedge i_core_clk);
      #1;
      n++;
    end while (o_rd_valid !== 1'b1 && n < 10);
    chk("read valid", 14'h1, {13'h0, o_rd_valid});
    chk("read data", {10'h000, exp}, {10'h000, o_rd_data});
  endtask

  // address moves only with select or strobe high
  always @(addr)
    if (!i_rst) chk("addr move", 14'h1, {13'h0, cs_n | we_n});
  // host and memory never drive the data lines together
  always @(posedge i_core_clk)
    if (!i_rst) chk("bus fight", 14'h0, {13'h0, oe & dev_oe});

  // pins idle in reset, controller ready one edge after release
  task automatic t_reset();
    repeat (16) @(posedge i_core_clk);
    chk("reset select", 14'h1, {13'h0, cs_n});
    chk("reset strobe", 14'h1, {13'h0, we_n});
    chk("reset drive", 14'h0, {13'h0, oe});
    i_rst <= 1'b0;
    @(posedge i_core_clk);
    #1;
    chk("ready after reset", 14'h1, {13'h0, o_req_ready});
    chk("select after reset", 14'h1, {13'h0, cs_n});
    $display("test reset done");
  endtask

  task automatic t_table();
    logic [13:0] a [4] = '{14'h0000, 14'h3fff, 14'h1555, 14'h2aaa};
    logic [3:0] d [4] = '{4'h5, 4'ha, 4'hf, 4'h0};
    for (int i = 0; i < 4; i++) wr(a[i], d[i]);
    for (int i = 0; i < 4; i++) rd(a[i], d[i]);
    $display("test table done");
  endtask
  task automatic t_b2b();
    wr(14'h3fff, 4'h3);
    rd(14'h3fff, 4'h3);
    $display("test back to back done");
  endtask
  task automatic t_retain();
    @(posedge i_core_clk);
    i_retain <= 1'b1;
    i_req <= 1'b1;
    i_req_write <= 1'b1;
    i_req_wdata <= 4'h9;
    i_req_addr <= 14'h0000;
    repeat (10) @(posedge i_core_clk);
    chk("select held off", 14'h1, {13'h0, cs_n});
    chk("no store", 14'h5, {10'h000, asrc_mem_model_i.mem[0]});
    i_req <= 1'b0;
    i_retain <= 1'b0;
    rd(14'h0000, 4'h5);
    $display("test retain done");
  endtask

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  initial begin
    t_reset();
    t_table();
    t_b2b();
    t_retain();
    tally_and_finish();
  end
  // watchdog well beyond the dozen or so transfers above
  initial begin
    #(20 * 2000);
    n_fail++;
    tally_and_finish();
  end
endmodule
